/* File: hw/dfc_pkg.sv */
// dfc_pkg: shared constants for the dma flag and control register front end.
// assumes a 32-bit classic wishbone slave port and seven dma channels.
package dfc_pkg;
    localparam int          NUM_CH       = 7;
    localparam int          CTL_W        = 15;
    localparam logic [31:0] BASE_ADDR    = 32'h4002_0000;
    localparam logic [7:0]  FLAGS_OFS    = 8'h00;
    localparam logic [7:0]  CLEAR_OFS    = 8'h04;
    localparam logic [7:0]  CTL_OFS      = 8'h08;
    localparam logic [7:0]  CTL_STRIDE   = 8'h14;
    localparam int          ANY_POS      = 0;
    localparam int          FULL_POS     = 1;
    localparam int          HALF_POS     = 2;
    localparam int          FAULT_POS    = 3;
    localparam int          ENABLE_POS   = 0;
    localparam int          FULL_IE_POS  = 1;
    localparam int          HALF_IE_POS  = 2;
    localparam int          FAULT_IE_POS = 3;
    localparam int          M2M_POS      = 14;
    localparam logic [14:0] CTL_LIVE_MSK = 15'h000f;
    localparam logic [14:0] CTL_RESET    = 15'h0000;
    localparam logic [3:0]  FULL_WORD    = 4'hf;
endpackage

/* File: hw/dfc_regs_if.sv */
// dfc_regs_if: carries write strobes and stored state between the bus
// front end and the flag and control banks; all on ref_clk.
`timescale 1ns/1ns
`default_nettype none
interface dfc_regs_if;
    import dfc_pkg::*;
    logic                          clr_wr;    // clear register write strobe
    logic [31:0]                   wdata;     // bus write data
    logic [NUM_CH-1:0]             ctl_wr;    // per-channel control write
    logic [NUM_CH-1:0]             fault_evt; // transfer error events
    logic [NUM_CH-1:0]             half_evt;  // half done events
    logic [NUM_CH-1:0]             full_evt;  // full done events
    logic [NUM_CH-1:0]             fault_q;   // stored fault flags
    logic [NUM_CH-1:0]             half_q;    // stored half flags
    logic [NUM_CH-1:0]             full_q;    // stored full flags
    logic [NUM_CH-1:0][CTL_W-1:0]  ctl_q;     // stored control words
    modport front (output clr_wr, wdata, ctl_wr, fault_evt, half_evt, full_evt,
                   input fault_q, half_q, full_q, ctl_q);
    modport flags (input clr_wr, wdata, fault_evt, half_evt, full_evt,
                   output fault_q, half_q, full_q);
    modport ctl   (input wdata, ctl_wr, output ctl_q);
endinterface
`default_nettype wire

/* File: hw/dfc_flag_bank.sv */
// dfc_flag_bank: sticky per-channel event flags with write-one-to-clear.
// assumes strobes arrive from the front end on the same clock.
`timescale 1ns/1ns
`default_nettype none
module dfc_flag_bank import dfc_pkg::*; (
    input  wire logic   ref_clk, // system clock
    input  wire logic   srst,    // sync reset, high
    dfc_regs_if.flags   rif      // front end link
);
    typedef struct packed {
        logic [NUM_CH-1:0] fault;
        logic [NUM_CH-1:0] half;
        logic [NUM_CH-1:0] full;
    } dfc_flag_s;
    dfc_flag_s         st_reg;
    dfc_flag_s         st_next;
    logic [NUM_CH-1:0] clr_f;
    logic [NUM_CH-1:0] clr_h;
    logic [NUM_CH-1:0] clr_u;
    // a channel's any-event clear bit wipes all three of its flags
    for (genvar i = 0; i < NUM_CH; i++) begin : g_clr
        assign clr_f[i] = rif.clr_wr & (rif.wdata[4*i+FAULT_POS] | rif.wdata[4*i+ANY_POS]); // R8 R9
        assign clr_h[i] = rif.clr_wr & (rif.wdata[4*i+HALF_POS] | rif.wdata[4*i+ANY_POS]); // R8 R9
        assign clr_u[i] = rif.clr_wr & (rif.wdata[4*i+FULL_POS] | rif.wdata[4*i+ANY_POS]); // R8 R9
    end
    always_comb begin
        // set wins over clear so a same-cycle event survives
        st_next.fault = (st_reg.fault & ~clr_f) | rif.fault_evt; // R3 R7 R15
        st_next.half  = (st_reg.half & ~clr_h) | rif.half_evt; // R4 R7 R15
        st_next.full  = (st_reg.full & ~clr_u) | rif.full_evt; // R5 R7 R15
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign rif.fault_q = st_reg.fault;
    assign rif.half_q  = st_reg.half;
    assign rif.full_q  = st_reg.full;
endmodule // dfc_flag_bank
`default_nettype wire

/* File: hw/dfc_ctl_bank.sv */
// dfc_ctl_bank: seven channel control words, configuration locked while enabled.
// assumes one write strobe per channel from the front end.
`timescale 1ns/1ns
`default_nettype none
module dfc_ctl_bank import dfc_pkg::*; (
    input  wire logic   ref_clk, // system clock
    input  wire logic   srst,    // sync reset, high
    dfc_regs_if.ctl     rif      // front end link
);
    typedef struct packed {
        logic [NUM_CH-1:0][CTL_W-1:0] ctl;
    } dfc_ctl_s;
    dfc_ctl_s                     st_reg;
    dfc_ctl_s                     st_next;
    logic [NUM_CH-1:0][CTL_W-1:0] row_next;
    for (genvar i = 0; i < NUM_CH; i++) begin : g_row
        // enable and event enables stay live; the rest freezes while running
        logic [CTL_W-1:0] keep_msk;
        assign keep_msk    = st_reg.ctl[i][ENABLE_POS] ? ~CTL_LIVE_MSK : '0; // R13
        assign row_next[i] = !rif.ctl_wr[i] ? st_reg.ctl[i]
                           : (st_reg.ctl[i] & keep_msk) | (rif.wdata[CTL_W-1:0] & ~keep_msk); // R10 R11
    end
    always_comb begin
        st_next.ctl = row_next;
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_reg.ctl <= {NUM_CH{CTL_RESET}}; // R10
        end else begin
            st_reg <= st_next;
        end
    end
    assign rif.ctl_q = st_reg.ctl;
endmodule // dfc_ctl_bank
`default_nettype wire

/* File: hw/dfc_dma_flag_ctl.sv */
// dfc_dma_flag_ctl: wishbone register front end of a seven-channel dma unit.
// assumes a classic wishbone master on ref_clk and event strobes from the
// transfer engine on the same clock, one cycle wide per event.
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// [R1] registers decode only inside the block based at 0x4002_0000.
// [R2] software uses only full 32-bit word accesses on these registers.
// [R3] a transfer error on channel x sets the fault flag at bit 4x+3.
// [R4] half of the programmed transfers done sets the half flag at bit 4x+2.
// [R5] the whole transfer done sets the full flag at bit 4x+1.
// [R6] bit 4x reads one exactly when any of channel x's three flags is set.
// [R7] flags are read-only and stay set until software clears them.
// [R8] writing one to a fault, half or full clear bit clears that flag only.
// [R9] writing one to a channel's any-event clear bit clears all its flags.
// [R10] each channel has a control word at 0x08 + 0x14*x, reset to zero.
// [R11] control bit 14 selects memory-to-memory mode, bits above read zero.
// [R12] software writes zeros to the reserved upper flag and clear bits.
// [R13] configuration fields ignore writes while the channel is enabled.
// [R14] a channel interrupt rises when a flagged event has its enable set.
// [R15] an event in the cycle of its clear write still sets its flag.
module dfc_dma_flag_ctl import dfc_pkg::*; (
    input  wire logic              ref_clk,           // system clock
    input  wire logic              srst,              // sync reset, high
    input  wire logic              wb_cyc_i,          // bus cycle
    input  wire logic              wb_stb_i,          // bus strobe
    input  wire logic              wb_we_i,           // write enable
    input  wire logic [31:0]       wb_adr_i,          // byte address
    input  wire logic [3:0]        wb_sel_i,          // byte lanes
    input  wire logic [31:0]       wb_dat_i,          // write data
    output logic      [31:0]       wb_dat_o,          // read data
    output logic                   wb_ack_o,          // acknowledge
    input  wire logic [NUM_CH-1:0] fault_evt,         // transfer error pulses
    input  wire logic [NUM_CH-1:0] half_evt,          // half done pulses
    input  wire logic [NUM_CH-1:0] full_evt,          // full done pulses
    output logic      [NUM_CH-1:0] channel_enable,    // channel run bits
    output logic      [NUM_CH-1:0] mem_to_mem_select, // m2m mode bits
    output logic      [NUM_CH-1:0] chan_irq           // channel interrupts
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic              ack;
        logic [31:0]       rdata;
        logic [NUM_CH-1:0] irq;
        logic [NUM_CH-1:0] en;
        logic [NUM_CH-1:0] m2m;
    } dfc_top_s;

    dfc_top_s          st_reg;
    dfc_top_s          st_next;
    dfc_regs_if        rif ();

    logic              req;
    logic              in_blk;
    logic [7:0]        ofs;
    logic              wr_ok;
    logic [NUM_CH-1:0] ctl_hit;
    logic [31:0]       flag_word;
    logic [NUM_CH-1:0] any_v;
    logic [NUM_CH-1:0] irq_v;
    logic [31:0]       rd_mux;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    assign req    = wb_cyc_i & wb_stb_i & ~st_reg.ack;
    assign in_blk = (wb_adr_i[31:8] == BASE_ADDR[31:8]); // R1
    assign ofs    = wb_adr_i[7:0];
    // partial-lane writes are dropped rather than merged
    assign wr_ok  = req & wb_we_i & in_blk & (wb_sel_i == FULL_WORD); // R2

    assign rif.wdata     = wb_dat_i;
    assign rif.clr_wr    = wr_ok & (ofs == CLEAR_OFS); // R8
    assign rif.fault_evt = fault_evt;
    assign rif.half_evt  = half_evt;
    assign rif.full_evt  = full_evt;

    // ------------------------------------------------------------
    // per-channel fields
    // ------------------------------------------------------------
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        assign ctl_hit[i] = (ofs == CTL_OFS + 8'(i) * CTL_STRIDE); // R10
        assign rif.ctl_wr[i] = wr_ok & ctl_hit[i];
        assign any_v[i] = rif.fault_q[i] | rif.half_q[i] | rif.full_q[i]; // R6
        assign flag_word[4*i+ANY_POS]   = any_v[i]; // R6
        assign flag_word[4*i+FULL_POS]  = rif.full_q[i]; // R5
        assign flag_word[4*i+HALF_POS]  = rif.half_q[i]; // R4
        assign flag_word[4*i+FAULT_POS] = rif.fault_q[i]; // R3
        assign irq_v[i] =
            (rif.fault_q[i] & rif.ctl_q[i][FAULT_IE_POS]) |
            (rif.half_q[i] & rif.ctl_q[i][HALF_IE_POS]) |
            (rif.full_q[i] & rif.ctl_q[i][FULL_IE_POS]); // R14
    end
    // reserved flag bits read as zero
    assign flag_word[31:4*NUM_CH] = '0;

    // ------------------------------------------------------------
    // read mux and bus answer
    // ------------------------------------------------------------
    always_comb begin
        rd_mux = '0;
        if (in_blk) begin
            if (ofs == FLAGS_OFS) begin
                rd_mux = flag_word; // R7
            end
            for (int i = 0; i < NUM_CH; i++) begin
                if (ctl_hit[i]) begin
                    rd_mux = {17'h0_0000, rif.ctl_q[i]}; // R11
                end
            end
        end
    end

    // answer comes one edge after the request; unmapped reads give zero
    always_comb begin
        st_next       = st_reg;
        st_next.ack   = req;
        st_next.rdata = req ? rd_mux : '0;
        st_next.irq   = irq_v; // R14
        for (int i = 0; i < NUM_CH; i++) begin
            st_next.en[i]  = rif.ctl_q[i][ENABLE_POS];
            st_next.m2m[i] = rif.ctl_q[i][M2M_POS]; // R11
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // banks
    // ------------------------------------------------------------
    dfc_flag_bank u_flags (
        .ref_clk (ref_clk),
        .srst    (srst),
        .rif     (rif.flags)
    );

    dfc_ctl_bank u_ctl (
        .ref_clk (ref_clk),
        .srst    (srst),
        .rif     (rif.ctl)
    );

    assign wb_ack_o          = st_reg.ack;
    assign wb_dat_o          = st_reg.rdata;
    assign chan_irq          = st_reg.irq;
    // channel outputs lag the stored control word by one cycle
    assign channel_enable    = st_reg.en;
    assign mem_to_mem_select = st_reg.m2m;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    logic [NUM_CH-1:0] clr_f_v;
    logic [NUM_CH-1:0] clr_h_v;
    logic [NUM_CH-1:0] clr_u_v;
    logic [NUM_CH-1:0] clr_g_v;
    for (genvar i = 0; i < NUM_CH; i++) begin : g_chk
        assign clr_f_v[i] = rif.clr_wr & (wb_dat_i[4*i+FAULT_POS] | wb_dat_i[4*i+ANY_POS]);
        assign clr_h_v[i] = rif.clr_wr & (wb_dat_i[4*i+HALF_POS] | wb_dat_i[4*i+ANY_POS]);
        assign clr_u_v[i] = rif.clr_wr & (wb_dat_i[4*i+FULL_POS] | wb_dat_i[4*i+ANY_POS]);
        assign clr_g_v[i] = rif.clr_wr & wb_dat_i[4*i+ANY_POS];
    end

    sequence s_out_read;
        req && !wb_we_i && !in_blk;
    endsequence

    sequence s_zero_answer;
        wb_ack_o && (wb_dat_o == 32'h0000_0000);
    endsequence

    sequence s_ctl0_read;
        req && !wb_we_i && in_blk && ctl_hit[0];
    endsequence

    sequence s_ctl_last_read;
        req && !wb_we_i && in_blk && ctl_hit[NUM_CH-1];
    endsequence

    sequence s_ctl0_write;
        req && wb_we_i && in_blk && ctl_hit[0] && (wb_sel_i == FULL_WORD);
    endsequence

    // writes outside the block or narrower than a word change nothing
    sequence s_lost_write;
        req && wb_we_i && (!in_blk || (wb_sel_i != FULL_WORD));
    endsequence

    sequence s_flags_read;
        req && !wb_we_i && in_blk && (ofs == FLAGS_OFS);
    endsequence

    sequence s_flags_write;
        req && wb_we_i && in_blk && (ofs == FLAGS_OFS);
    endsequence

    sequence s_clear_read;
        req && !wb_we_i && in_blk && (ofs == CLEAR_OFS);
    endsequence

    chk_base_decode: assert property (s_out_read |=> s_zero_answer) // R1
        else $error("read outside the block did not answer zero");

    chk_fault_set: assert property ((fault_evt != 0) |=> // R3
        ((rif.fault_q & $past(fault_evt)) == $past(fault_evt)))
        else $error("fault event did not set its flag");

    chk_half_set: assert property ((half_evt != 0) |=> // R4
        ((rif.half_q & $past(half_evt)) == $past(half_evt)))
        else $error("half event did not set its flag");

    chk_full_set: assert property ((full_evt != 0) |=> // R5
        ((rif.full_q & $past(full_evt)) == $past(full_evt)))
        else $error("full event did not set its flag");

    chk_any_flag: assert property ( // R6
        flag_word[4*NUM_CH-1:0] != 28'h000_0000 |-> (any_v != 0))
        else $error("any-event bits disagree with the flags");

    // only channel 0 is decoded bit by bit; the others share its layout
    chk_flags_read: assert property (s_flags_read |=> wb_ack_o && // R6
        (wb_dat_o[31:28] == 4'h0) &&
        (wb_dat_o[3:0] == {$past(rif.fault_q[0]), $past(rif.half_q[0]),
                           $past(rif.full_q[0]),
                           $past(rif.fault_q[0] | rif.half_q[0] | rif.full_q[0])}))
        else $error("flag word read back wrong");

    // ------------------------------------------------------------
    // flag clearing and stickiness
    // ------------------------------------------------------------
    chk_flag_sticky: assert property (1'b1 |=> // R7
        (($past(rif.fault_q) & ~$past(clr_f_v) & ~rif.fault_q) == 0))
        else $error("fault flag dropped without a clear");

    chk_half_sticky: assert property (1'b1 |=> // R7
        (($past(rif.half_q) & ~$past(clr_h_v) & ~rif.half_q) == 0))
        else $error("half flag dropped without a clear");

    chk_full_sticky: assert property (1'b1 |=> // R7
        (($past(rif.full_q) & ~$past(clr_u_v) & ~rif.full_q) == 0))
        else $error("full flag dropped without a clear");

    chk_flags_ro: assert property ( // R7
        s_flags_write ##0 ((fault_evt | half_evt | full_evt) == 0) |=>
        ({rif.fault_q, rif.half_q, rif.full_q} == $past({rif.fault_q, rif.half_q, rif.full_q})))
        else $error("flag register took a software write");

    chk_fault_clear: assert property ((clr_f_v != 0) |=> // R8
        ((rif.fault_q & $past(clr_f_v) & ~$past(fault_evt)) == 0))
        else $error("fault clear bit did not clear the flag");

    chk_half_clear: assert property ((clr_h_v != 0) |=> // R8
        ((rif.half_q & $past(clr_h_v) & ~$past(half_evt)) == 0))
        else $error("half clear bit did not clear the flag");

    chk_full_clear: assert property ((clr_u_v != 0) |=> // R8
        ((rif.full_q & $past(clr_u_v) & ~$past(full_evt)) == 0))
        else $error("full clear bit did not clear the flag");

    chk_clear_read_zero: assert property (s_clear_read |=> // R8
        wb_ack_o && (wb_dat_o == 32'h0000_0000))
        else $error("clear register did not read as zero");

    chk_global_clear: assert property ((clr_g_v != 0) |=> // R9
        ((any_v & $past(clr_g_v) & ~$past(fault_evt | half_evt | full_evt)) == 0))
        else $error("any-event clear left a flag set");

    chk_set_wins: assert property ((fault_evt[0] && clr_f_v[0]) |=> // R15
        rif.fault_q[0] ##1 (rif.fault_q[0] || $past(clr_f_v[0])))
        else $error("event lost against a same-cycle clear");

    // ------------------------------------------------------------
    // control words and bus answer
    // ------------------------------------------------------------
    chk_ctl_read: assert property (s_ctl0_read |=> // R10
        wb_ack_o && (wb_dat_o == {17'h0_0000, $past(rif.ctl_q[0])}))
        else $error("control word read back wrong");

    chk_ctl_last_read: assert property (s_ctl_last_read |=> wb_ack_o && // R10
        (wb_dat_o == {17'h0_0000, $past(rif.ctl_q[NUM_CH-1])}))
        else $error("last control word read back wrong");

    chk_ctl_write: assert property (s_ctl0_write ##0 !rif.ctl_q[0][ENABLE_POS] |=> // R10
        (rif.ctl_q[0] == $past(wb_dat_i[CTL_W-1:0])))
        else $error("control write did not land");

    chk_enable_out: assert property (1'b1 |=> // R10
        (channel_enable[0] == $past(rif.ctl_q[0][ENABLE_POS])) &&
        (channel_enable[NUM_CH-1] == $past(rif.ctl_q[NUM_CH-1][ENABLE_POS])))
        else $error("channel enable output wrong");

    // reserved control bits are only looked at after a control read
    chk_m2m_out: assert property (1'b1 |=> // R11
        (mem_to_mem_select[0] == $past(rif.ctl_q[0][M2M_POS])) &&
        (!$past(req && !wb_we_i && in_blk && (ctl_hit != 0)) ||
         (wb_dat_o[31:15] == 17'h0_0000)))
        else $error("m2m output or reserved bits wrong");

    chk_m2m_last: assert property (1'b1 |=> // R11
        (mem_to_mem_select[NUM_CH-1] == $past(rif.ctl_q[NUM_CH-1][M2M_POS])))
        else $error("last m2m output wrong");

    chk_live_bits: assert property (s_ctl0_write |=> // R13
        (rif.ctl_q[0][FAULT_IE_POS:ENABLE_POS] == $past(wb_dat_i[FAULT_IE_POS:ENABLE_POS])))
        else $error("enable or event enable bits not written");

    chk_cfg_locked: assert property (rif.ctl_q[0][ENABLE_POS] |=> // R13
        (rif.ctl_q[0][CTL_W-1:4] == $past(rif.ctl_q[0][CTL_W-1:4])))
        else $error("configuration changed while enabled");

    chk_cfg_lock_last: assert property (rif.ctl_q[NUM_CH-1][ENABLE_POS] |=> // R13
        (rif.ctl_q[NUM_CH-1][CTL_W-1:4] == $past(rif.ctl_q[NUM_CH-1][CTL_W-1:4])))
        else $error("last configuration changed while enabled");

    chk_write_dropped: assert property (s_lost_write |=> // R1 R2
        (rif.ctl_q == $past(rif.ctl_q)))
        else $error("dropped write changed a control word");

    chk_irq_follow: assert property (1'b1 |=> // R14
        (chan_irq == $past(irq_v)) ##1 (chan_irq == $past(irq_v)))
        else $error("interrupt does not follow flags and enables");

    // with all three event enables off the channel stays quiet
    chk_irq_quiet: assert property ( // R14
        (rif.ctl_q[0][FAULT_IE_POS:FULL_IE_POS] == 3'b000) |=> !chan_irq[0])
        else $error("interrupt raised with its enables off");

    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge held for two cycles");

    chk_ack_answer: assert property (req |=> wb_ack_o)
        else $error("request not answered in the next cycle");

    chk_dat_idle: assert property (!wb_ack_o |-> (wb_dat_o == 32'h0000_0000))
        else $error("read data not zero outside the answer");

endmodule // dfc_dma_flag_ctl
`default_nettype wire

/* File: sim/tb_top.sv */
// tb_top: self-checking bench for the dma flag and control register front end.
// assumes dfc_pkg and the hw/ design files compile first; single ref_clk domain.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import dfc_pkg::*;
    logic              ref_clk, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [31:0]       wb_adr_i, wb_dat_i, wb_dat_o;
    logic [3:0]        wb_sel_i;
    logic [NUM_CH-1:0] fault_evt, half_evt, full_evt;
    logic [NUM_CH-1:0] channel_enable, mem_to_mem_select, chan_irq;
    logic [NUM_CH-1:0] ef, eh, eu;
    logic [14:0]       ectl [NUM_CH];
    logic [31:0]       rd, wd;
    logic [NUM_CH-1:0] m1, m2, m3, xen, xm2m;
    int                miscompares, n_compared, cycles;

    dfc_dma_flag_ctl u_dfc_dma_flag_ctl (
        .ref_clk(ref_clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .fault_evt(fault_evt), .half_evt(half_evt), .full_evt(full_evt),
        .channel_enable(channel_enable), .mem_to_mem_select(mem_to_mem_select),
        .chan_irq(chan_irq));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one classic cycle; evt pulses fault events at the taking edge only
    task automatic bus(input logic we, input logic [31:0] adr, input logic [31:0] dat,
                       input logic [3:0] sel, input logic [NUM_CH-1:0] evt);
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we;
        wb_adr_i <= adr; wb_dat_i <= dat; wb_sel_i <= sel; fault_evt <= evt;
        do begin
            @(posedge ref_clk);
            fault_evt <= '0;
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
    endtask

    task automatic pulse(input logic [NUM_CH-1:0] f, h, u);
        @(posedge ref_clk);
        fault_evt <= f; half_evt <= h; full_evt <= u;
        @(posedge ref_clk);
        fault_evt <= '0; half_evt <= '0; full_evt <= '0;
        ef |= f; eh |= h; eu |= u;
    endtask

    function automatic logic [31:0] flag_word();
        logic [31:0] w;
        w = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            w[4*i+FAULT_POS] = ef[i];
            w[4*i+HALF_POS]  = eh[i];
            w[4*i+FULL_POS]  = eu[i];
            w[4*i+ANY_POS]   = ef[i] | eh[i] | eu[i];
        end
        return w;
    endfunction

    function automatic void apply_clear(input logic [31:0] c);
        for (int i = 0; i < NUM_CH; i++) begin
            if (c[4*i+ANY_POS] || c[4*i+FAULT_POS]) ef[i] = 1'b0;
            if (c[4*i+ANY_POS] || c[4*i+HALF_POS]) eh[i] = 1'b0;
            if (c[4*i+ANY_POS] || c[4*i+FULL_POS]) eu[i] = 1'b0;
        end
    endfunction

    function automatic logic [31:0] ctl_adr(input int x);
        return BASE_ADDR + 32'(CTL_OFS) + 32'(CTL_STRIDE) * 32'(x);
    endfunction

    // ------------------------------------------------------------
    // clock, reset, timeout
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
    end

    initial begin
        srst = 1'b1; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0;
        wb_adr_i = '0; wb_dat_i = '0; wb_sel_i = 4'h0;
        fault_evt = '0; half_evt = '0; full_evt = '0;
        ef = '0; eh = '0; eu = '0; miscompares = 0; n_compared = 0; cycles = 0;
        for (int i = 0; i < NUM_CH; i++) ectl[i] = CTL_RESET;
        void'($urandom(94));
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        // reset values
        bus(1'b0, BASE_ADDR + 32'(FLAGS_OFS), '0, FULL_WORD, '0);
        check("flags_rst", rd, 32'h0000_0000);
        bus(1'b0, BASE_ADDR + 32'(CLEAR_OFS), '0, FULL_WORD, '0);
        check("clear_rd", rd, 32'h0000_0000);
        for (int i = 0; i < NUM_CH; i++) begin
            bus(1'b0, ctl_adr(i), '0, FULL_WORD, '0);
            check("ctl_rst", rd, 32'h0000_0000);
        end
        // random events then random partial clears; upper bits kept zero
        for (int k = 0; k < 8; k++) begin
            m1 = 7'($urandom); m2 = 7'($urandom); m3 = 7'($urandom);
            pulse(m1, m2, m3);
            bus(1'b0, BASE_ADDR + 32'(FLAGS_OFS), '0, FULL_WORD, '0);
            check("flags_set", rd, flag_word());
            wd = $urandom & 32'h0fff_ffff;
            bus(1'b1, BASE_ADDR + 32'(CLEAR_OFS), wd, FULL_WORD, '0);
            apply_clear(wd);
            bus(1'b0, BASE_ADDR + 32'(FLAGS_OFS), '0, FULL_WORD, '0);
            check("flags_clr", rd, flag_word());
        end
        // event in the very cycle of a full clear survives
        pulse(7'h7f, 7'h7f, 7'h7f);
        bus(1'b1, BASE_ADDR + 32'(CLEAR_OFS), 32'h0fff_ffff, FULL_WORD, 7'h09);
        ef = 7'h09; eh = '0; eu = '0;
        bus(1'b0, BASE_ADDR + 32'(FLAGS_OFS), '0, FULL_WORD, '0);
        check("flags_race", rd, flag_word());
        // flags are not writable by software
        bus(1'b1, BASE_ADDR + 32'(FLAGS_OFS), 32'h0fff_ffff, FULL_WORD, '0);
        bus(1'b0, BASE_ADDR + 32'(FLAGS_OFS), '0, FULL_WORD, '0);
        check("flags_ro", rd, flag_word());
        // control words: random writes, lock of bits 14:4 while enabled
        for (int k = 0; k < 4; k++) begin
            for (int i = 0; i < NUM_CH; i++) begin
                wd = $urandom;
                bus(1'b1, ctl_adr(i), wd, FULL_WORD, '0);
                ectl[i] = ectl[i][ENABLE_POS] ? {ectl[i][14:4], wd[3:0]} : wd[14:0];
                bus(1'b0, ctl_adr(i), '0, FULL_WORD, '0);
                check("ctl_rw", rd, {17'h0, ectl[i]});
            end
        end
        for (int i = 0; i < NUM_CH; i++) begin
            xen[i] = ectl[i][ENABLE_POS];
            xm2m[i] = ectl[i][M2M_POS];
        end
        check("enable_out", 32'(channel_enable), 32'(xen));
        check("m2m_out", 32'(mem_to_mem_select), 32'(xm2m));
        // channel interrupt follows flags gated by the event enables
        pulse(7'h55, 7'h2a, 7'h7f);
        repeat (2) @(posedge ref_clk);
        for (int i = 0; i < NUM_CH; i++) begin
            m1[i] = (ef[i] & ectl[i][FAULT_IE_POS]) | (eh[i] & ectl[i][HALF_IE_POS])
                  | (eu[i] & ectl[i][FULL_IE_POS]);
        end
        check("irq_on", 32'(chan_irq), 32'(m1));
        bus(1'b1, BASE_ADDR + 32'(CLEAR_OFS), 32'h0111_1111, FULL_WORD, '0);
        repeat (2) @(posedge ref_clk);
        check("irq_off", 32'(chan_irq), 32'h0);
        // partial lane write and writes outside the block are dropped
        bus(1'b1, ctl_adr(0), 32'h0000_7ffe, 4'h3, '0);
        bus(1'b1, 32'h4012_0008, 32'h0000_7ffe, FULL_WORD, '0);
        bus(1'b0, ctl_adr(0), '0, FULL_WORD, '0);
        check("ctl_keep", rd, {17'h0, ectl[0]});
        bus(1'b0, 32'h4003_0000, '0, FULL_WORD, '0);
        check("unmapped", rd, 32'h0000_0000);
        summarize();
    end
endmodule // tb_top
`default_nettype wire
